// ==== pbm_port_mux.sv ====
// What this block does
// - An analog pin ignores function, open-drain and drive settings; output and direction only pick its line.
// - A non-analog pin with an enabled function takes its value or direction from that function.
// - Without analog or function a pin is plain digital I/O; start-up default.
// - Each pin attaches to the four-line analog bus by its analog select bit.
// - In analog mode the pull-up bit closes the analog switch; 0 is high impedance.
// - In analog mode direction and output bits pick the line, direction is MSB.
// - PWM0 and PWM1 enables drive pins 0 and 1 from the PWM signals.
// - Slow clock enable drives pin 3 with the 16 kHz clock from fmax.
// - Cpu clock enable drives pin 2 with the cpu clock.
// - The cpu clock on pin 2 follows the cpu clock select bit.
// - Sync serial enable makes pins 4 and 5 open-drain S0 and S1.
// - An output serial line drives its pin from its line value register.
// - Async transmit enable drives pin 6 as the transmit output.
// - Async receive enable uses pin 7 as the receive input.
// - Output, direction, open-drain, analog reset to 0; pull-ups reset to 1.
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/100ps
module pbm_port_mux
   import pbm_pkg::*;
#(
   parameter int unsigned PINS = PBM_PINS
)(
   input  wire logic                  sys_clk,             // System clock, 50 MHz
   input  wire logic                  reset,               // Async reset, active high
   input  wire logic                  psel,                // APB select
   input  wire logic                  penable,             // APB enable
   input  wire logic                  pwrite,              // APB write
   input  wire logic [PBM_ADDR_W-1:0] paddr,               // APB byte address
   input  wire logic [PBM_DATA_W-1:0] pwdata,              // APB write data
   output logic      [PBM_DATA_W-1:0] prdata,              // APB read data
   output logic                       pready,              // APB ready
   output logic                       pslverr,             // APB error
   input  wire logic                  pwm0_level,          // PWM0 counter output
   input  wire logic                  pwm1_level,          // PWM1 counter output
   input  wire logic                  async_tx_level,      // Async serial transmit level
   output logic                       async_rx_level,      // Async serial receive level
   input  wire logic                  sync_line0_is_out,   // S0 is an output
   input  wire logic                  sync_line1_is_out,   // S1 is an output
   output logic                       sync_line0_level,    // Level seen on S0
   output logic                       sync_line1_level,    // Level seen on S1
   input  wire logic [PINS-1:0]       pad_in,              // Pad input levels
   output logic      [PINS-1:0]       pad_out,             // Pad output levels
   output logic      [PINS-1:0]       pad_oe,              // Pad driver enables
   output logic      [PINS-1:0]       pad_pullup_en,       // Pad pull-up enables
   output logic      [PINS-1:0]       pad_input_en,        // Pad input buffer enables
   output logic      [PINS-1:0]       ana_connect,         // Analog switch closed
   output logic      [2*PINS-1:0]     ana_line_sel         // Analog line, 2 bits a pin
);

   if (PINS != PBM_PINS) begin : g_pins_check
      $error("Function map is fixed to eight pins");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   logic [7:0]      output_q;
   logic [7:0]      direction_q;
   logic [7:0]      open_q;
   logic [7:0]      pullup_q;
   logic [7:0]      analog_select_q;
   logic [7:0]      func_ctrl_q;
   logic [1:0]      sync_val_q;
   logic [7:0]      pad_in_meta_q;
   logic [7:0]      pad_in_q;
   logic [PBM_DATA_W-1:0] prdata_q;
   logic            pslverr_q;
   logic [PBM_DATA_W-1:0] rdata_d;
   logic            addr_ok_d;
   logic            setup;
   logic            wr_access;

   assign setup     = psel & ~penable;
   assign wr_access = psel & penable & pwrite;

   // Zero wait states: read data is captured in the setup cycle
   assign pready  = 1'b1;
   assign prdata  = prdata_q;
   assign pslverr = pslverr_q;

   always_comb begin
      rdata_d   = '0;
      addr_ok_d = 1'b1;
      unique case (paddr)
         PBM_OFS_OUTPUT:    rdata_d[7:0] = output_q;
         PBM_OFS_INPUT:     rdata_d[7:0] = pad_in_q;
         PBM_OFS_DIRECTION: rdata_d[7:0] = direction_q;
         PBM_OFS_OPEN:      rdata_d[7:0] = open_q;
         PBM_OFS_PULLUP:    rdata_d[7:0] = pullup_q;
         PBM_OFS_ANALOG:    rdata_d[7:0] = analog_select_q;
         PBM_OFS_FUNC_CTRL: rdata_d[7:0] = func_ctrl_q;
         PBM_OFS_SYNC_VAL:  rdata_d[1:0] = sync_val_q;
         PBM_OFS_DRIVE_STS: rdata_d[7:0] = pad_oe;
         default:           addr_ok_d    = 1'b0;
      endcase
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (setup) begin
         prdata_q  <= pwrite ? 32'h0000_0000 : rdata_d;
         pslverr_q <= ~addr_ok_d;
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         output_q        <= PBM_RST_OUTPUT;
         direction_q     <= PBM_RST_DIRECTION;
         open_q          <= PBM_RST_OPEN;
         pullup_q        <= PBM_RST_PULLUP;
         analog_select_q <= PBM_RST_ANALOG;
      end else if (wr_access) begin
         if (paddr == PBM_OFS_OUTPUT)    output_q        <= pwdata[7:0];
         if (paddr == PBM_OFS_DIRECTION) direction_q     <= pwdata[7:0];
         if (paddr == PBM_OFS_OPEN)      open_q          <= pwdata[7:0];
         if (paddr == PBM_OFS_PULLUP)    pullup_q        <= pwdata[7:0];
         if (paddr == PBM_OFS_ANALOG)    analog_select_q <= pwdata[7:0];
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         func_ctrl_q <= PBM_RST_FUNC_CTRL;
         sync_val_q  <= PBM_RST_SYNC_VAL;
      end else if (wr_access) begin
         if (paddr == PBM_OFS_FUNC_CTRL) func_ctrl_q <= pwdata[7:0];
         if (paddr == PBM_OFS_SYNC_VAL)  sync_val_q  <= pwdata[1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pad input synchroniser
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         pad_in_meta_q <= 8'h00;
         pad_in_q      <= 8'h00;
      end else begin
         pad_in_meta_q <= pad_in;
         pad_in_q      <= pad_in_meta_q;
      end
   end

   // Idle level of an async line is high when the receiver is off
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         async_rx_level   <= 1'b1;
         sync_line0_level <= 1'b1;
         sync_line1_level <= 1'b1;
      end else begin
         async_rx_level   <= func_ctrl_q[PBM_FC_RX] ? pad_in_q[PBM_PIN_RX] : 1'b1;
         sync_line0_level <= pad_in_q[PBM_PIN_SYNC0];
         sync_line1_level <= pad_in_q[PBM_PIN_SYNC1];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Function sources
   logic slow_clk;
   logic cpu_clk;

   pbm_clock_gen u_clock_gen (
      .sys_clk          (sys_clk),
      .reset            (reset),
      .cpu_clock_select (func_ctrl_q[PBM_FC_CPU_CLOCK_SELECT]),
      .slow_clk_q       (slow_clk),
      .cpu_clk_q        (cpu_clk)
   );

   logic [7:0] fn_val_en;
   logic [7:0] fn_val;
   logic [7:0] fn_dir_en;
   logic [7:0] fn_dir;
   logic [7:0] fn_open_en;
   logic       sync_en;

   assign sync_en = func_ctrl_q[PBM_FC_SYNC];

   // Clock and PWM outputs leave direction to software
   assign fn_val_en = {1'b0, func_ctrl_q[PBM_FC_TX], {2{sync_en}},
                       func_ctrl_q[PBM_FC_SLOWCK], func_ctrl_q[PBM_FC_CPUCK],
                       func_ctrl_q[PBM_FC_PWM1], func_ctrl_q[PBM_FC_PWM0]};
   assign fn_val    = {1'b0, async_tx_level, sync_val_q[PBM_SV_LINE1],
                       sync_val_q[PBM_SV_LINE0], slow_clk, cpu_clk,
                       pwm1_level, pwm0_level};
   assign fn_dir_en = {func_ctrl_q[PBM_FC_RX], func_ctrl_q[PBM_FC_TX],
                       {2{sync_en}}, 4'h0};
   assign fn_dir    = {1'b0, 1'b1, sync_line1_is_out, sync_line0_is_out, 4'h0};
   assign fn_open_en = {2'h0, {2{sync_en}}, 4'h0};

   ////////////////////////////////////////////////////////////////////////////
   // Per-pin priority resolve and pad flops
   genvar g;
   generate
      for (g = 0; g < PBM_PINS; g++) begin : gen_pin
         logic       r_out;
         logic       r_oe;
         logic       r_pu;
         logic       r_ien;
         logic       r_ana;
         logic [1:0] r_line;

         pbm_pin_resolve u_resolve (
            .analog_sel  (analog_select_q[g]),
            .pullup_bit  (pullup_q[g]),
            .dir_bit     (direction_q[g]),
            .out_bit     (output_q[g]),
            .open_bit    (open_q[g]),
            .fn_val_en   (fn_val_en[g]),
            .fn_val      (fn_val[g]),
            .fn_dir_en   (fn_dir_en[g]),
            .fn_dir      (fn_dir[g]),
            .fn_open_en  (fn_open_en[g]),
            .pad_out     (r_out),
            .pad_oe      (r_oe),
            .pad_pullup  (r_pu),
            .pad_in_en   (r_ien),
            .ana_connect (r_ana),
            .ana_line    (r_line)
         );

         // Pads are registered so they never glitch on a register write
         always_ff @(posedge sys_clk or posedge reset) begin
            if (reset) begin
               pad_out[g]              <= 1'b0;
               pad_oe[g]               <= 1'b0;
               pad_pullup_en[g]        <= 1'b1;
               pad_input_en[g]         <= 1'b1;
               ana_connect[g]          <= 1'b0;
               ana_line_sel[2*g +: 2]  <= 2'h0;
            end else begin
               pad_out[g]              <= r_out;
               pad_oe[g]               <= r_oe;
               pad_pullup_en[g]        <= r_pu;
               pad_input_en[g]         <= r_ien;
               ana_connect[g]          <= r_ana;
               ana_line_sel[2*g +: 2]  <= r_line;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   a_analog_no_drive: assert property (
      ##1 ((pad_oe & $past(analog_select_q)) == 8'h00))
      else $error("Analog pin is driven");

   a_analog_line_pick: assert property (
      analog_select_q[2] |=> ana_line_sel[5:4] == $past({direction_q[2], output_q[2]}))
      else $error("Analog line number wrong");

   a_analog_switch: assert property (
      analog_select_q[2] |=> ana_connect[2] == $past(pullup_q[2]) && !pad_oe[2])
      else $error("Analog switch does not follow pull-up bit");

   a_pwm0_drive: assert property (
      (!analog_select_q[0] && func_ctrl_q[PBM_FC_PWM0] && !open_q[0])
      |=> pad_out[0] == $past(pwm0_level) && pad_oe[0] == $past(direction_q[0]))
      else $error("Pin 0 does not follow PWM0");

   a_slow_clk_drive: assert property (
      (!analog_select_q[3] && func_ctrl_q[PBM_FC_SLOWCK] && !open_q[3])
      |=> pad_out[3] == $past(slow_clk))
      else $error("Pin 3 does not carry the slow clock");

   a_cpu_clk_drive: assert property (
      (!analog_select_q[2] && func_ctrl_q[PBM_FC_CPUCK] && !open_q[2])
      |=> pad_out[2] == $past(cpu_clk))
      else $error("Pin 2 does not carry the cpu clock");

   a_sync_open_drain: assert property (
      (!analog_select_q[4] && sync_en) |=> !(pad_oe[4] && pad_out[4]))
      else $error("Serial line 0 drives high");

   a_sync_line0_low: assert property (
      (!analog_select_q[4] && sync_en && sync_line0_is_out && !sync_val_q[0])
      |=> pad_oe[4] && !pad_out[4])
      else $error("Serial line 0 value not driven");

   a_tx_drive: assert property (
      (!analog_select_q[6] && func_ctrl_q[PBM_FC_TX] && !open_q[6])
      |=> pad_oe[6] && pad_out[6] == $past(async_tx_level))
      else $error("Transmit pin not driven");

   a_rx_input: assert property (
      (!analog_select_q[7] && func_ctrl_q[PBM_FC_RX]) |=> !pad_oe[7] ##2 1'b1)
      else $error("Receive pin is driven");

   a_digital_plain: assert property (
      (!analog_select_q[1] && !func_ctrl_q[PBM_FC_PWM1])
      |=> pad_oe[1] == $past(direction_q[1] & ~(open_q[1] & output_q[1])))
      else $error("Plain digital pin enable wrong");

   a_pwm1_drive: assert property (
      (!analog_select_q[1] && func_ctrl_q[PBM_FC_PWM1] && !open_q[1])
      |=> pad_out[1] == $past(pwm1_level))
      else $error("Pin 1 does not follow PWM1");

   a_sync_line1_low: assert property (
      (!analog_select_q[5] && sync_en && sync_line1_is_out && !sync_val_q[1])
      |=> pad_oe[5] && !pad_out[5])
      else $error("Serial line 1 value not driven");

   a_rx_level: assert property (
      func_ctrl_q[PBM_FC_RX] |=> async_rx_level == $past(pad_in_q[PBM_PIN_RX]))
      else $error("Receive level does not follow pin 7");

   a_analog_input_off: assert property (
      ##1 (pad_input_en == ~$past(analog_select_q)))
      else $error("Input buffer wrong for analog mode");

   // A driven pin never burns current in its own pull-up
   a_pullup_driven: assert property (
      ##1 ((pad_oe & pad_pullup_en) == 8'h00))
      else $error("Pull-up left on at a driven pin");

   a_digital_value: assert property (
      (!analog_select_q[4] && !sync_en && !open_q[4])
      |=> pad_out[4] == $past(output_q[4]))
      else $error("Plain digital pin value wrong");

   a_reset_pads: assert property (disable iff (1'b0)
      $fell(reset) |-> pad_pullup_en == 8'hFF && pad_oe == 8'h00 && ana_connect == 8'h00)
      else $error("Pad reset state wrong");

   a_reset_values: assert property (disable iff (1'b0)
      $fell(reset) |-> pullup_q == PBM_RST_PULLUP && output_q == PBM_RST_OUTPUT
                       && direction_q == PBM_RST_DIRECTION && analog_select_q == PBM_RST_ANALOG)
      else $error("Configuration reset values wrong");

   c_analog_connect: cover property (analog_select_q[2] && pullup_q[2] ##1 ana_connect[2]);
   c_pwm_output:     cover property (func_ctrl_q[PBM_FC_PWM0] && direction_q[0] ##1 pad_oe[0]);
   c_sync_serial:    cover property (sync_en && sync_line0_is_out ##1 pad_oe[4]);
   c_tx_output:      cover property (func_ctrl_q[PBM_FC_TX] ##1 pad_oe[6]);

endmodule // pbm_port_mux

// ==== pbm_pkg.sv ====
package pbm_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Port shape
   localparam int unsigned PBM_PINS   = 8;
   localparam int unsigned PBM_ADDR_W = 8;
   localparam int unsigned PBM_DATA_W = 32;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte addresses on the APB
   localparam logic [7:0] PBM_OFS_OUTPUT    = 8'h00;
   localparam logic [7:0] PBM_OFS_INPUT     = 8'h04;
   localparam logic [7:0] PBM_OFS_DIRECTION = 8'h08;
   localparam logic [7:0] PBM_OFS_OPEN      = 8'h0C;
   localparam logic [7:0] PBM_OFS_PULLUP    = 8'h10;
   localparam logic [7:0] PBM_OFS_ANALOG    = 8'h14;
   localparam logic [7:0] PBM_OFS_FUNC_CTRL = 8'h18;
   localparam logic [7:0] PBM_OFS_SYNC_VAL  = 8'h1C;
   localparam logic [7:0] PBM_OFS_DRIVE_STS = 8'h20;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [7:0] PBM_RST_OUTPUT    = 8'h00;
   localparam logic [7:0] PBM_RST_DIRECTION = 8'h00;
   localparam logic [7:0] PBM_RST_OPEN      = 8'h00;
   localparam logic [7:0] PBM_RST_PULLUP    = 8'hFF;
   localparam logic [7:0] PBM_RST_ANALOG    = 8'h00;
   localparam logic [7:0] PBM_RST_FUNC_CTRL = 8'h00;
   localparam logic [1:0] PBM_RST_SYNC_VAL  = 2'h0;

   ////////////////////////////////////////////////////////////////////////////
   // Function control and sync value register fields
   localparam int unsigned PBM_FC_PWM0    = 0;
   localparam int unsigned PBM_FC_PWM1    = 1;
   localparam int unsigned PBM_FC_SLOWCK  = 2;
   localparam int unsigned PBM_FC_CPUCK   = 3;
   localparam int unsigned PBM_FC_CPU_CLOCK_SELECT  = 4;
   localparam int unsigned PBM_FC_SYNC    = 5;
   localparam int unsigned PBM_FC_TX      = 6;
   localparam int unsigned PBM_FC_RX      = 7;
   localparam int unsigned PBM_SV_LINE0   = 0;
   localparam int unsigned PBM_SV_LINE1   = 1;

   ////////////////////////////////////////////////////////////////////////////
   // Pins owned by each function
   localparam int unsigned PBM_PIN_PWM0   = 0;
   localparam int unsigned PBM_PIN_PWM1   = 1;
   localparam int unsigned PBM_PIN_CPUCK  = 2;
   localparam int unsigned PBM_PIN_SLOWCK = 3;
   localparam int unsigned PBM_PIN_SYNC0  = 4;
   localparam int unsigned PBM_PIN_SYNC1  = 5;
   localparam int unsigned PBM_PIN_TX     = 6;
   localparam int unsigned PBM_PIN_RX     = 7;

   ////////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int unsigned PBM_SYS_CLK_KHZ  = 50000;
   localparam int unsigned PBM_SLOW_CLK_KHZ = 16;
   localparam int unsigned PBM_CPU_LOW_KHZ  = 32;
   localparam int unsigned PBM_SLOW_HALF    = PBM_SYS_CLK_KHZ / (2 * PBM_SLOW_CLK_KHZ);
   localparam int unsigned PBM_CPU_LOW_HALF = PBM_SYS_CLK_KHZ / (2 * PBM_CPU_LOW_KHZ);
   localparam int unsigned PBM_DIV_W        = 11;

endpackage

// ==== pbm_clock_gen.sv ====
`timescale 1ns/100ps
module pbm_clock_gen
   import pbm_pkg::*;
(
   input  wire logic sys_clk,          // System clock
   input  wire logic reset,            // Async reset, active high
   input  wire logic cpu_clock_select, // 0: fast cpu clock, 1: 32 kHz
   output logic      slow_clk_q,       // 16 kHz square wave
   output logic      cpu_clk_q         // Cpu clock image
);

   logic [PBM_DIV_W-1:0] slow_cnt_q;
   logic [PBM_DIV_W-1:0] cpu_cnt_q;
   logic [1:0]           fast_cnt_q;
   logic                 cpu_low_q;

   if (PBM_SLOW_HALF >= (1 << PBM_DIV_W) || PBM_CPU_LOW_HALF >= (1 << PBM_DIV_W)
       || PBM_SLOW_HALF < 1 || PBM_CPU_LOW_HALF < 1) begin : g_div_check
      $error("Clock divider does not fit its counter");
   end

   // Derived from the fastest clock, free running
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         slow_cnt_q <= '0;
         slow_clk_q <= 1'b0;
      end else if (slow_cnt_q == PBM_DIV_W'(PBM_SLOW_HALF - 1)) begin
         slow_cnt_q <= '0;
         slow_clk_q <= ~slow_clk_q;
      end else begin
         slow_cnt_q <= slow_cnt_q + 1'b1;
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         cpu_cnt_q  <= '0;
         cpu_low_q  <= 1'b0;
         fast_cnt_q <= 2'h0;
      end else begin
         fast_cnt_q <= fast_cnt_q + 2'h1;
         if (cpu_cnt_q == PBM_DIV_W'(PBM_CPU_LOW_HALF - 1)) begin
            cpu_cnt_q <= '0;
            cpu_low_q <= ~cpu_low_q;
         end else begin
            cpu_cnt_q <= cpu_cnt_q + 1'b1;
         end
      end
   end

   // Select picks the fmax/4 image or the 32 kHz image
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         cpu_clk_q <= 1'b0;
      end else begin
         cpu_clk_q <= cpu_clock_select ? cpu_low_q : fast_cnt_q[1];
      end
   end

endmodule // pbm_clock_gen

// ==== pbm_pin_resolve.sv ====
`timescale 1ns/100ps
module pbm_pin_resolve (
   input  wire logic analog_sel,  // Pin in analog mode
   input  wire logic pullup_bit,  // Pull-up / analog switch bit
   input  wire logic dir_bit,     // Direction bit, 1 = output
   input  wire logic out_bit,     // Output value bit
   input  wire logic open_bit,    // Open-drain bit
   input  wire logic fn_val_en,   // Function owns the value
   input  wire logic fn_val,      // Function value
   input  wire logic fn_dir_en,   // Function owns the direction
   input  wire logic fn_dir,      // Function direction
   input  wire logic fn_open_en,  // Function forces open drain
   output logic      pad_out,     // Level to drive
   output logic      pad_oe,      // Pad driver enable
   output logic      pad_pullup,  // Pull-up resistor on
   output logic      pad_in_en,   // Digital input buffer on
   output logic      ana_connect, // Analog switch closed
   output logic [1:0] ana_line    // Analog line number
);

   logic val;
   logic dir;
   logic od;

   always_comb begin
      val = fn_val_en ? fn_val : out_bit;
      dir = fn_dir_en ? fn_dir : dir_bit;
      od  = fn_open_en | open_bit;
      if (analog_sel) begin
         pad_out     = 1'b0;
         pad_oe      = 1'b0;
         pad_pullup  = 1'b0;
         pad_in_en   = 1'b0;
         ana_connect = pullup_bit;
         ana_line    = {dir_bit, out_bit};
      end else begin
         // Open drain drives only low
         pad_out     = od ? 1'b0 : val;
         pad_oe      = dir & ~(od & val);
         pad_pullup  = pullup_bit & ~(dir & ~(od & val));
         pad_in_en   = 1'b1;
         ana_connect = 1'b0;
         ana_line    = 2'h0;
      end
   end

endmodule // pbm_pin_resolve

// ==== pbm_pad_model.sv ====
`timescale 1ns/100ps
module pbm_pad_model (
   input  wire logic       sys_clk, // System clock
   input  wire logic [7:0] pad_out, // Levels from the port
   input  wire logic [7:0] pad_oe,  // Driver enables
   input  wire logic [7:0] pad_pu,  // Pull-up enables
   input  wire logic [7:0] ext_lvl, // Levels forced from outside
   output logic      [7:0] pad_in,  // Resolved pin levels
   output logic      [2:0] src      // Tx, pwm1, pwm0 sources
);
   logic [4:0] cnt_q = 5'h00;
   ////////////////////////////////////////////////////////////////////////////
   // A released pin follows the pull-up, else the outside level
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         pad_in[i] = pad_oe[i] ? pad_out[i] : (pad_pu[i] ? 1'b1 : ext_lvl[i]);
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Sources change often and unevenly so a stale copy shows up
   always_ff @(posedge sys_clk) begin
      cnt_q <= cnt_q + 5'h01;
   end
   assign src = {cnt_q[2], cnt_q[1], cnt_q[0] ^ cnt_q[3]};
endmodule // pbm_pad_model

// ==== testbench.sv ====
`timescale 1ns/100ps
module testbench
   import pbm_pkg::*;
;
   logic        sys_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        s0o = 1'b0, s1o = 1'b0, pready, pslverr, rx, s0, s1, e;
   logic [7:0]  paddr = 8'h00, ext = 8'h00, pin, pout, poe, ppu, pie, acon;
   logic [31:0] pwdata = 32'h0000_0000, prdata, r;
   logic [15:0] asel;
   logic [2:0]  src, p;
   int          mismatches = 0, compares = 0, cyc = 0, n;

   pbm_port_mux u_pbm_port_mux (.sys_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .pwm0_level(src[0]), .pwm1_level(src[1]),
      .async_tx_level(src[2]), .async_rx_level(rx), .sync_line0_is_out(s0o),
      .sync_line1_is_out(s1o), .sync_line0_level(s0), .sync_line1_level(s1), .pad_in(pin),
      .pad_out(pout), .pad_oe(poe), .pad_pullup_en(ppu), .pad_input_en(pie),
      .ana_connect(acon), .ana_line_sel(asel));
   pbm_pad_model u_pbm_pad_model (.sys_clk, .pad_out(pout), .pad_oe(poe), .pad_pu(ppu),
      .ext_lvl(ext), .pad_in(pin), .src);

   initial begin
      forever #10 sys_clk = ~sys_clk;
   end
   ////////////////////////////////////////////////////////////////////////////
   task stop_test;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] x);
      compares++;
      if (g !== x) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, g, x);
      end
   endtask
   // The master allows wait states: it waits for pready, bounded by the timeout
   task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge sys_clk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      apb(a, 1'b1, {24'h00_0000, d});
   endtask
   task settle(input int c);
      repeat (c) @(posedge sys_clk);
      #1;
   endtask
   task count(input int b, input int c);
      n = 0;
      p[0] = pout[b];
      repeat (c) begin
         settle(1);
         if (pout[b] !== p[0]) n++;
         p[0] = pout[b];
      end
   endtask
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         stop_test();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge sys_clk);
      reset <= 1'b0;
      settle(1);
      chk({poe, ppu, pie, acon}, 32'h00FF_FF00);
      for (int k = 0; k < 10; k++) begin
         apb(8'(4 * k), 1'b0, 32'h0000_0000);
         chk(r, {24'h00_0000, (k == 1 || k == 4) ? 8'hFF : 8'h00});
         chk(e, k == 9);
      end
      wr(PBM_OFS_DIRECTION, 8'hFF);
      wr(PBM_OFS_OUTPUT, 8'hA5);
      settle(2);
      chk({pout, poe, ppu}, 24'hA5_FF00);
      for (int l = 0; l < 4; l++) begin
         wr(PBM_OFS_ANALOG, 8'h04);
         wr(PBM_OFS_DIRECTION, l[1] ? 8'hFF : 8'hFB);
         wr(PBM_OFS_OUTPUT, l[0] ? 8'h04 : 8'h00);
         settle(2);
         chk({asel[5:4], acon[2], poe[2], pie[2]}, {l[1:0], 3'b100});
      end
      wr(PBM_OFS_PULLUP, 8'hFB);
      settle(2);
      chk(acon, 8'h00);
      wr(PBM_OFS_ANALOG, 8'h01);
      wr(PBM_OFS_FUNC_CTRL, 8'h01);
      settle(2);
      chk({acon[0], poe[0]}, 2'b10);
      wr(PBM_OFS_ANALOG, 8'h00);
      wr(PBM_OFS_PULLUP, 8'h7F);
      wr(PBM_OFS_DIRECTION, 8'hFF);
      wr(PBM_OFS_FUNC_CTRL, 8'hC3);
      settle(2);
      repeat (12) begin
         @(posedge sys_clk);
         p = src;
         #1;
         chk({pout[6], pout[1:0], poe[7:6]}, {p, 2'b01});
      end
      for (int v = 0; v < 2; v++) begin
         ext[7] = v[0];
         settle(5);
         chk(rx, v[0]);
      end
      @(posedge sys_clk);
      s0o <= 1'b1;
      wr(PBM_OFS_FUNC_CTRL, 8'h20);
      settle(2);
      chk({poe[5:4], pout[4]}, 3'b010);
      wr(PBM_OFS_SYNC_VAL, 8'h01);
      settle(4);
      chk({poe[4], s0, s1}, 3'b011);
      @(posedge sys_clk);
      s1o <= 1'b1;
      settle(4);
      chk({poe[5], pout[5], s1}, 3'b100);
      wr(PBM_OFS_FUNC_CTRL, 8'h08);
      settle(2);
      count(2, 16);
      chk(n, 8);
      wr(PBM_OFS_FUNC_CTRL, 8'h18);
      settle(4);
      count(2, 16);
      chk(n < 2, 1);
      wr(PBM_OFS_FUNC_CTRL, 8'h04);
      count(3, 1600);
      chk(n inside {1, 2}, 1);
      stop_test();
   end
endmodule // testbench
